// File: hw/atf_pkg.sv
package atf_pkg;
  // Task file offsets on the host address lines
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_ERRFEAT = 3'h1;
  localparam logic [2:0] OFS_COUNT = 3'h2;
  localparam logic [2:0] OFS_SECTOR = 3'h3;
  localparam logic [2:0] OFS_CYLLO = 3'h4;
  localparam logic [2:0] OFS_CYLHI = 3'h5;
  localparam logic [2:0] OFS_DEVHEAD = 3'h6;
  localparam logic [2:0] OFS_CMDSTAT = 3'h7;
  // Drive/head field positions
  localparam int LBA_MODE_BIT = 6;
  localparam int DRIVE_SEL_BIT = 4;
  localparam int HEAD_MSB = 3;
  // Status byte bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_SEEKDONE = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_CORRECTED_ERROR_FLAG = 2;
  localparam int ST_ERR = 0;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_DEVHEAD = 8'ha0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Zero sector count stands for this many sectors
  localparam logic [8:0] FULL_SECTORS = 9'h100;
  localparam logic [7:0] ONE_SECTOR = 8'h01;
  // Command engine phase
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CMD = 2'b01,
    PH_XFER = 2'b10
  } atf_phase_e;
endpackage

// File: hw/atf_task_file.sv
`timescale 1ns/1ps
// Overview of operation
// - 16-bit data port moves buffer words
// - Data shares error address; lanes by width
// - Offset 0, CE2 low: D15-D8 to feature
// - Feature meaning depends on next command
// - Zero sector count means 256 sectors
// - Successful command leaves count at zero
// - Failed command leaves remaining sectors
// - Sector number is start sector/LBA 7-0
// - Cylinder low is cylinder/LBA 15-8
// - Cylinder high is cylinder/LBA 23-16
// - Drive/head bit 6 picks LBA
// - Head select bits give LBA 27-24
// - Data moves only while data request set
// - Host register writes ignored while busy
module atf_task_file
  import atf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic iordN,
  input wire logic iowrN,
  input wire logic ce1N,
  input wire logic ce2N,
  input wire logic [2:0] hostAddr,
  input wire logic [15:0] hostDataIn,
  output logic [15:0] hostDataOut,
  output logic hostDataOeN,
  output logic cmdStart,
  output logic [7:0] cmdCode,
  output logic [7:0] cmdFeature,
  output logic [8:0] cmdSectors,
  output logic cmdLbaMode,
  output logic [27:0] cmdLba,
  output logic cmdDrive,
  input wire logic xferReq,
  input wire logic sectorDone,
  input wire logic cmdDone,
  input wire logic cmdOk,
  input wire logic [7:0] errorCode,
  input wire logic corrected,
  input wire logic devReady,
  output logic wrWordValid,
  output logic [15:0] wrWord,
  output logic rdWordTake,
  input wire logic [15:0] rdWord,
  output logic busy,
  output logic drq
);

  // Whole module state
  typedef struct packed {
    logic iordS1;
    logic iordS2;
    logic iordPrev;
    logic iowrS1;
    logic iowrS2;
    logic iowrPrev;
    logic [1:0] ceS1;
    logic [1:0] ceS2;
    logic [2:0] addrS1;
    logic [2:0] addrS2;
    logic [15:0] dinS1;
    logic [15:0] dinS2;
    logic [7:0] feature;
    logic [7:0] count;
    logic [7:0] sector;
    logic [7:0] cylLo;
    logic [7:0] cylHi;
    logic [7:0] devHead;
    logic errFlag;
    atf_phase_e phase;
    logic [15:0] readData;
    logic oeN;
    logic wrValid;
    logic [15:0] wrData;
    logic rdTake;
    logic start;
    logic [7:0] code;
    logic [7:0] featSnap;
    logic [8:0] sectors;
    logic lbaMode;
    logic [27:0] lba;
    logic drive;
  } atf_state_s;

  atf_state_s st;
  atf_state_s next_st;
  // Synchronised strobe events
  logic rdEv;
  logic rdEnd;
  logic wrEv;
  logic [7:0] statusByte;

  // Register hit: offset with given chip enable pattern (active low)
  function automatic logic atf_hit(input logic [2:0] a, input logic [1:0] ce,
                                   input logic [2:0] ofs, input logic [1:0] want);
    return (a == ofs) && (ce == want);
  endfunction

  // Read start, read end, write end on synced strobes
  assign rdEv = !st.iordS2 && st.iordPrev;
  assign rdEnd = st.iordS2 && !st.iordPrev;
  assign wrEv = st.iowrS2 && !st.iowrPrev;
  assign busy = (st.phase == PH_CMD);
  assign drq = (st.phase == PH_XFER);

  // Status byte as seen by the host
  always_comb begin
    statusByte = RST_BYTE;
    statusByte[ST_BUSY] = busy;
    statusByte[ST_READY] = devReady;
    statusByte[ST_SEEKDONE] = devReady;
    statusByte[ST_DRQ] = drq;
    statusByte[ST_CORRECTED_ERROR_FLAG] = corrected;
    statusByte[ST_ERR] = st.errFlag;
  end

  // Next state
  always_comb begin
    next_st = st;
    // Two-flop synchronisers on all host bus pins; engine inputs used directly
    next_st.iordS1 = iordN;
    next_st.iordS2 = st.iordS1;
    next_st.iordPrev = st.iordS2;
    next_st.iowrS1 = iowrN;
    next_st.iowrS2 = st.iowrS1;
    next_st.iowrPrev = st.iowrS2;
    next_st.ceS1 = {ce2N, ce1N};
    next_st.ceS2 = st.ceS1;
    next_st.addrS1 = hostAddr;
    next_st.addrS2 = st.addrS1;
    next_st.dinS1 = hostDataIn;
    next_st.dinS2 = st.dinS1;
    // Pulses default low
    next_st.wrValid = 1'b0;
    next_st.rdTake = 1'b0;
    next_st.start = 1'b0;
    // Bus driven only while read strobe held
    next_st.oeN = st.iordS2;

    // Read cycle start: latch the addressed register
    if (rdEv) begin
      if (atf_hit(st.addrS2, st.ceS2, OFS_DATA, 2'b10)) begin
        next_st.readData = drq ? rdWord : RST_WORD;
      end else if (atf_hit(st.addrS2, st.ceS2, OFS_DATA, 2'b01)) begin
        next_st.readData = {errorCode, RST_BYTE};
      end else if (st.ceS2 == 2'b10) begin
        // Byte registers sit on the low lane
        unique case (st.addrS2)
          OFS_ERRFEAT: next_st.readData = {RST_BYTE, errorCode};
          OFS_COUNT: next_st.readData = {RST_BYTE, st.count};
          OFS_SECTOR: next_st.readData = {RST_BYTE, st.sector};
          OFS_CYLLO: next_st.readData = {RST_BYTE, st.cylLo};
          OFS_CYLHI: next_st.readData = {RST_BYTE, st.cylHi};
          OFS_DEVHEAD: next_st.readData = {RST_BYTE, st.devHead};
          OFS_CMDSTAT: next_st.readData = {RST_BYTE, statusByte};
          OFS_DATA: next_st.readData = RST_WORD;
        endcase
      end else begin
        // Unselected or alternate space reads as status
        next_st.readData = {RST_BYTE, statusByte};
      end
    end

    // word consumed at end of data read
    if (rdEnd && drq && atf_hit(st.addrS2, st.ceS2, OFS_DATA, 2'b10)) begin
      next_st.rdTake = 1'b1;
    end

    // Write cycle end
    if (wrEv) begin
      if (atf_hit(st.addrS2, st.ceS2, OFS_DATA, 2'b01) && !busy) begin
        next_st.feature = st.dinS2[15:8];
      end
      // data port write only with request
      if (atf_hit(st.addrS2, st.ceS2, OFS_DATA, 2'b10) && drq) begin
        next_st.wrValid = 1'b1;
        next_st.wrData = st.dinS2;
      end
      if (st.ceS2 == 2'b10 && !busy) begin
        unique case (st.addrS2)
          OFS_ERRFEAT: next_st.feature = st.dinS2[7:0];
          OFS_COUNT: next_st.count = st.dinS2[7:0];
          OFS_SECTOR: next_st.sector = st.dinS2[7:0];
          OFS_CYLLO: next_st.cylLo = st.dinS2[7:0];
          OFS_CYLHI: next_st.cylHi = st.dinS2[7:0];
          OFS_DEVHEAD: next_st.devHead = st.dinS2[7:0];
          OFS_CMDSTAT: begin
            next_st.start = 1'b1;
            next_st.phase = PH_CMD;
            next_st.errFlag = 1'b0;
            next_st.code = st.dinS2[7:0];
            next_st.featSnap = st.feature;
            next_st.sectors = (st.count == RST_BYTE) ? FULL_SECTORS : {1'b0, st.count};
            next_st.lbaMode = st.devHead[LBA_MODE_BIT];
            next_st.drive = st.devHead[DRIVE_SEL_BIT];
            next_st.lba = {st.devHead[HEAD_MSB:0], st.cylHi, st.cylLo, st.sector};
          end
          OFS_DATA: next_st.count = st.count;
        endcase
      end
    end

    // Engine progress
    unique case (st.phase)
      PH_IDLE: next_st.phase = next_st.phase;
      PH_CMD: begin
        // Engine asks for data
        if (xferReq) begin
          next_st.phase = PH_XFER;
        end
      end
      PH_XFER: begin
        // Sector boundary returns to busy
        if (sectorDone && !xferReq) begin
          next_st.phase = PH_CMD;
        end
      end
      default: next_st.phase = PH_IDLE;
    endcase

    if (sectorDone && st.phase != PH_IDLE) begin
      next_st.count = st.count - ONE_SECTOR;
    end

    // Command completion
    if (cmdDone && st.phase != PH_IDLE) begin
      next_st.phase = PH_IDLE;
      if (cmdOk) begin
        next_st.count = RST_BYTE;
      end else begin
        next_st.errFlag = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.iordS1 <= 1'b1;
      st.iordS2 <= 1'b1;
      st.iordPrev <= 1'b1;
      st.iowrS1 <= 1'b1;
      st.iowrS2 <= 1'b1;
      st.iowrPrev <= 1'b1;
      st.ceS1 <= 2'b11;
      st.ceS2 <= 2'b11;
      st.devHead <= RST_DEVHEAD;
      st.phase <= PH_IDLE;
      st.oeN <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign hostDataOut = st.readData;
  assign hostDataOeN = st.oeN;
  assign cmdStart = st.start;
  assign cmdCode = st.code;
  assign cmdFeature = st.featSnap;
  assign cmdSectors = st.sectors;
  assign cmdLbaMode = st.lbaMode;
  assign cmdLba = st.lba;
  assign cmdDrive = st.drive;
  assign wrWordValid = st.wrValid;
  assign wrWord = st.wrData;
  assign rdWordTake = st.rdTake;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  count_zero_full_a: assert property (
    cmdStart |-> (cmdSectors == (($past(st.count) == RST_BYTE) ? FULL_SECTORS
                                 : {1'b0, $past(st.count)})))
    else $error("sector count snapshot wrong");

  done_ok_zero_a: assert property (
    (cmdDone && cmdOk && st.phase != PH_IDLE) |=> (st.count == RST_BYTE) && !busy)
    else $error("count not zero after success");

  done_fail_keep_a: assert property (
    (cmdDone && !cmdOk && !sectorDone && st.phase != PH_IDLE) |=>
      $stable(st.count) && st.errFlag)
    else $error("count changed on failure");

  sector_dec_a: assert property (
    (sectorDone && !cmdDone && st.phase != PH_IDLE) |=>
      (st.count == $past(st.count) - ONE_SECTOR))
    else $error("count not decremented");

  feature_upper_a: assert property (
    (wrEv && !busy && atf_hit(st.addrS2, st.ceS2, OFS_DATA, 2'b01)) |=>
      (st.feature == $past(st.dinS2[15:8])))
    else $error("feature not captured from upper lane");

  lba_assembly_a: assert property (
    cmdStart |-> (cmdLba == {$past(st.devHead[HEAD_MSB:0]), $past(st.cylHi),
                             $past(st.cylLo), $past(st.sector)})
                 && (cmdLbaMode == $past(st.devHead[LBA_MODE_BIT])) && busy)
    else $error("address snapshot wrong");

  data_req_gate_a: assert property (
    (wrWordValid || rdWordTake) |-> ($past(st.phase) == PH_XFER))
    else $error("data moved without request");

  busy_lock_a: assert property (
    (wrEv && busy) |=> $stable(st.sector) && $stable(st.cylLo) && $stable(st.cylHi))
    else $error("task file written while busy");

  data_read_a: assert property (
    (rdEv && drq && atf_hit(st.addrS2, st.ceS2, OFS_DATA, 2'b10)) |=>
      (hostDataOut == $past(rdWord)) && !hostDataOeN)
    else $error("data port read wrong");

endmodule // atf_task_file

// File: tb/atf_host_model.sv
`timescale 1ns/1ps
// Host controller issuing task file I/O cycles
module atf_host_model (
  input wire logic clk,
  output logic iordN,
  output logic iowrN,
  output logic ce1N,
  output logic ce2N,
  output logic [2:0] hostAddr,
  output logic [15:0] hostDataIn
);
  // Idle bus at time zero
  initial begin
    iordN = 1'b1;
    iowrN = 1'b1;
    ce1N = 1'b1;
    ce2N = 1'b1;
    hostAddr = 3'h0;
    hostDataIn = 16'h0000;
  end
  // Wait some edges
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Write cycle, strobe and hold both 4 clocks
  task automatic ioWr(input logic c1, input logic c2, input logic [2:0] a,
                      input logic [15:0] d);
    @(posedge clk);
    ce1N <= c1;
    ce2N <= c2;
    hostAddr <= a;
    hostDataIn <= d;
    cyc(1);
    iowrN <= 1'b0;
    cyc(4);
    iowrN <= 1'b1;
    cyc(4);
    ce1N <= 1'b1;
    ce2N <= 1'b1;
    // Released bus shows inverse data
    hostDataIn <= ~d;
    cyc(3);
  endtask
  // Read cycle, long enough for the 3 edge answer
  task automatic ioRd(input logic c1, input logic c2, input logic [2:0] a);
    @(posedge clk);
    ce1N <= c1;
    ce2N <= c2;
    hostAddr <= a;
    cyc(1);
    iordN <= 1'b0;
    cyc(6);
    iordN <= 1'b1;
    cyc(5);
    ce1N <= 1'b1;
    ce2N <= 1'b1;
    cyc(2);
  endtask
endmodule // atf_host_model

// File: tb/test_ata_task_file_registers.sv
`timescale 1ns/1ps
// Host model on the pins, engine driven by the bench
module test_ata_task_file_registers import atf_pkg::*;;
  logic clk = 1'b0, rst = 1'b1;
  logic iordN, iowrN, ce1N, ce2N, hostDataOeN, cmdStart, cmdLbaMode, cmdDrive;
  logic xferReq = 1'b0, sectorDone = 1'b0, cmdDone = 1'b0, cmdOk = 1'b0;
  logic corrected = 1'b0, devReady = 1'b1, wrWordValid, rdWordTake, busy, drq;
  logic [2:0] hostAddr;
  logic [7:0] cmdCode, cmdFeature, errorCode = 8'h00;
  logic [8:0] cmdSectors;
  logic [15:0] hostDataIn, hostDataOut, wrWord, rdWord = 16'h0000;
  logic [27:0] cmdLba;
  logic [55:0] expQ[$]; // Expected results, oldest first
  logic [55:0] snap; // Command snapshot as one word
  int nTake = 0; // Read words handed back to the engine
  int nFail = 0, checksDone = 0, cycles = 0;
  logic prevOeN = 1'b1;
  always #2.5 clk = ~clk;
  atf_host_model u_atf_host_model (.clk(clk), .iordN(iordN), .iowrN(iowrN),
    .ce1N(ce1N), .ce2N(ce2N), .hostAddr(hostAddr), .hostDataIn(hostDataIn));
  atf_task_file u_atf_task_file (.clk(clk), .rst(rst), .iordN(iordN), .iowrN(iowrN),
    .ce1N(ce1N), .ce2N(ce2N), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
    .hostDataOut(hostDataOut), .hostDataOeN(hostDataOeN), .cmdStart(cmdStart),
    .cmdCode(cmdCode), .cmdFeature(cmdFeature), .cmdSectors(cmdSectors),
    .cmdLbaMode(cmdLbaMode), .cmdLba(cmdLba), .cmdDrive(cmdDrive), .xferReq(xferReq),
    .sectorDone(sectorDone), .cmdDone(cmdDone), .cmdOk(cmdOk), .errorCode(errorCode),
    .corrected(corrected), .devReady(devReady), .wrWordValid(wrWordValid),
    .wrWord(wrWord), .rdWordTake(rdWordTake), .rdWord(rdWord), .busy(busy), .drq(drq));
  // Code, drive, feature, mode, sectors and address side by side
  assign snap = {cmdCode, 1'b0, cmdDrive, cmdFeature, cmdLbaMode, cmdSectors, cmdLba};
  // Compare and count
  task automatic check(input logic [55:0] seen, input logic [55:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic wrapUp();
    if (expQ.size() != 0) begin
      nFail++;
    end
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Host write and host read with noted result
  task automatic wr(input logic c1, input logic c2, input logic [2:0] a, input logic [15:0] d);
    u_atf_host_model.ioWr(c1, c2, a, d);
  endtask
  task automatic rd(input logic c1, input logic c2, input logic [2:0] a, input logic [15:0] e);
    expQ.push_back({40'h0, e});
    u_atf_host_model.ioRd(c1, c2, a);
  endtask
  // One cycle engine pulses
  task automatic eng(input logic s, input logic d, input logic ok);
    @(posedge clk);
    sectorDone <= s;
    cmdDone <= d;
    cmdOk <= ok;
    @(posedge clk);
    sectorDone <= 1'b0;
    cmdDone <= 1'b0;
    cmdOk <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Cycle ceiling, running out counts as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      nFail++;
      wrapUp();
    end
  end
  // Output watcher
  always @(posedge clk) begin
    prevOeN <= hostDataOeN;
    // Count words handed back after data reads
    if (rdWordTake === 1'b1) begin
      nTake++;
    end
    if (prevOeN === 1'b1 && hostDataOeN === 1'b0) begin
      check({40'h0, hostDataOut}, expQ.pop_front());
    end
    if (cmdStart === 1'b1) begin
      check(snap, expQ.pop_front());
    end
    if (wrWordValid === 1'b1) begin
      check({40'h0, wrWord}, expQ.pop_front());
    end
  end
  // Main sequence
  initial begin
    logic [7:0] sec, lo, hi, feat, cnt;
    logic [3:0] head;
    logic drv, lba;
    logic [15:0] w;
    void'($urandom(32'ha6920ab5));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(1'b0, 1'b1, OFS_COUNT, 16'h0000);
    rd(1'b0, 1'b1, OFS_DATA, 16'h0000);
    check(56'(nTake), 56'h0);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      {sec, lo, hi, feat} = $urandom();
      {head, drv} = 5'($urandom());
      w = 16'($urandom());
      lba = (i == 1);
      cnt = (i == 1) ? 8'h03 : 8'h00;
      errorCode <= 8'($urandom());
      // feature by upper lane, then by low lane
      if (i == 0) begin
        wr(1'b1, 1'b0, OFS_DATA, {feat, 8'h00});
      end else begin
        wr(1'b0, 1'b1, OFS_ERRFEAT, {8'h00, feat});
      end
      wr(1'b0, 1'b1, OFS_COUNT, {8'h00, cnt});
      wr(1'b0, 1'b1, OFS_SECTOR, {8'h00, sec});
      wr(1'b0, 1'b1, OFS_CYLLO, {8'h00, lo});
      wr(1'b0, 1'b1, OFS_CYLHI, {8'h00, hi});
      wr(1'b0, 1'b1, OFS_DEVHEAD, {8'h00, 1'b1, lba, 1'b1, drv, head});
      expQ.push_back({8'h20, 1'b0, drv, feat, lba,
                      (cnt == 8'h00) ? FULL_SECTORS : {1'b0, cnt}, head, hi, lo, sec});
      wr(1'b0, 1'b1, OFS_CMDSTAT, 16'h0020);
      wr(1'b0, 1'b1, OFS_COUNT, 16'h0077);
      check({55'h0, busy}, 56'h1);
      xferReq <= 1'b1;
      corrected <= 1'($urandom());
      for (int k = 0; k < 50 && drq !== 1'b1; k++) @(posedge clk);
      check({55'h0, drq}, 56'h1);
      expQ.push_back({40'h0, w});
      wr(1'b0, 1'b1, OFS_DATA, w);
      rdWord <= ~w;
      rd(1'b0, 1'b1, OFS_DATA, ~w);
      check(56'(nTake), 56'(i + 1));
      xferReq <= 1'b0;
      eng(1'b1, 1'b0, 1'b0);
      eng(1'b0, 1'b1, (i == 0));
      rd(1'b0, 1'b1, OFS_COUNT, (i == 0) ? 16'h0000 : 16'h0002);
      rd(1'b0, 1'b1, OFS_CMDSTAT, {8'h00, 4'h5, 1'b0, corrected, 1'b0, (i == 1)});
      // error byte on upper lane and on low lane
      rd(1'b1, 1'b0, OFS_DATA, {errorCode, 8'h00});
      rd(1'b0, 1'b1, OFS_ERRFEAT, {8'h00, errorCode});
      rd(1'b0, 1'b1, OFS_SECTOR, {8'h00, sec});
      rd(1'b0, 1'b1, OFS_DEVHEAD, {8'h00, 1'b1, lba, 1'b1, drv, head});
      $display("test %0d done", i);
    end
    repeat (5) @(posedge clk);
    wrapUp();
  end
endmodule // test_ata_task_file_registers
